/* rtl/cmmg_cfg.svh */
// constants for the processor memory map glue: strap pattern, decode codes, widths
// assumes inclusion by bare name from each design file that needs them
`ifndef CMMG_CFG_SVH
`define CMMG_CFG_SVH
`define CMMG_STRAP_PATTERN   16'hB4FE
`define CMMG_STRAP_LOW_MASK  16'h4B01
`define CMMG_IO_HIT_NIBBLE   4'hF
`define CMMG_MAP_PAGE_HI     4'hF
`define CMMG_MAP_PAGE_MID    3'h0
`define CMMG_MAP_CS_CODE     2'h0
`define CMMG_MAP_SEL_CODE    2'h1
`define CMMG_MAP_SEL_LOW     5'h00
`define CMMG_RAM_BASE_TOP    4'h0
`define CMMG_ROM1_TOP        4'h1
`define CMMG_ROM2_TOP        4'h2
`define CMMG_ROM3_TOP        4'h3
`define CMMG_MAP_RESET       8'h00
`define CMMG_ROW_BITS        7
`define CMMG_COL_BITS        4
`endif

/* rtl/cmmg_pkg.sv */
// types for the processor memory map glue
// assumes cmmg_cfg.svh holds the numeric constants
package cmmg_pkg;
  typedef enum logic [1:0] {
    CMMG_SEL_NONE,
    CMMG_SEL_ROM,
    CMMG_SEL_RAM
  } cmmg_sel_e;
  typedef logic [19:0] cmmg_addr_t;
endpackage

/* rtl/cmmg_flag_decode.sv */
// flag and read/write decode gates, registered
// assumes processor flags and controls synchronous to clk
`timescale 1ns/1ps
`include "cmmg_cfg.svh"
module cmmg_flag_decode (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // processor flags and controls
  input  wire logic cpu_flag_bit0,
  input  wire logic cpu_flag_bit1,
  input  wire logic cpu_row_strobe_n,
  input  wire logic high_byte_rw_ctl,
  input  wire logic low_byte_rw_ctl,
  input  wire logic priority_input,
  // decoded outputs
  output logic      refresh_reg,
  output logic      ram_row_strobe_n_reg,
  output logic      io_cycle_qualifier_n_reg,
  output logic      read_cycle_reg,
  output logic      read_strobe_n_reg,
  output logic      low_byte_write_n_reg
);
  logic refresh_next;
  logic read_next;

  assign refresh_next = cpu_flag_bit0 & ~cpu_flag_bit1;
  assign read_next    = high_byte_rw_ctl & low_byte_rw_ctl;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      refresh_reg              <= 1'b0;
      ram_row_strobe_n_reg     <= 1'b1;
      io_cycle_qualifier_n_reg <= 1'b1;
    end else begin
      refresh_reg              <= refresh_next;
      ram_row_strobe_n_reg     <= refresh_next | cpu_row_strobe_n;
      io_cycle_qualifier_n_reg <= cpu_flag_bit0 | cpu_flag_bit1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      read_cycle_reg       <= 1'b0;
      read_strobe_n_reg    <= 1'b1;
      low_byte_write_n_reg <= 1'b1;
    end else begin
      read_cycle_reg       <= read_next;
      read_strobe_n_reg    <= ~(read_next & priority_input);
      low_byte_write_n_reg <= ~(~low_byte_rw_ctl & priority_input);
    end
  end

  AST_REF_DECODE: assert property (@(posedge clk) disable iff (!rstn)
    (cpu_flag_bit0 && !cpu_flag_bit1) |=> (refresh_reg && ram_row_strobe_n_reg))
    else $error("refresh decode wrong");
  AST_RAS_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
    !(cpu_flag_bit0 && !cpu_flag_bit1) |=> (ram_row_strobe_n_reg == $past(cpu_row_strobe_n)))
    else $error("row strobe does not follow");
  AST_IOQ: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> (io_cycle_qualifier_n_reg == ($past(cpu_flag_bit0) || $past(cpu_flag_bit1))))
    else $error("io qualifier wrong");
  AST_RD_STROBE: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> (!read_strobe_n_reg == (read_cycle_reg && $past(priority_input))))
    else $error("read strobe wrong");
  AST_WLB: assert property (@(posedge clk) disable iff (!rstn)
    (!low_byte_rw_ctl && priority_input) |=> !low_byte_write_n_reg)
    else $error("low byte write missing");
endmodule

/* rtl/cmmg_mem_map.sv */
// memory map: input mux, adders holding the translation, control flop, output mux
// assumes latched address and peripheral data synchronous to clk
`timescale 1ns/1ps
`include "cmmg_cfg.svh"
module cmmg_mem_map (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // selects and strobes
  input  wire logic        map_cs_n,
  input  wire logic        map_sel_n,
  input  wire logic        low_byte_write_n,
  input  wire logic        priority_low_n,
  // buses
  input  wire logic [15:1] latched_addr_bus,
  input  wire logic [7:0]  peripheral_data_bus,
  // results
  output logic [7:0]       map_value_reg,
  output logic             map_on_reg,
  output logic [19:12]     translated_hi
);
  logic [3:0] mux_nibble;

  function automatic logic [3:0] add_nibble(input logic [3:0] a, input logic [3:0] b);
    add_nibble = 4'(a + b);
  endfunction

  // the low nibble path carries bits the adders never load
  assign mux_nibble = !map_cs_n ? latched_addr_bus[15:12] : latched_addr_bus[4:1];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      map_value_reg <= `CMMG_MAP_RESET;
    end else if (!map_cs_n && !low_byte_write_n) begin
      map_value_reg <= {add_nibble(mux_nibble, peripheral_data_bus[7:4]),
                        add_nibble(mux_nibble, peripheral_data_bus[3:0])};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      map_on_reg <= 1'b0;
    end else if (!map_sel_n && !priority_low_n) begin
      map_on_reg <= peripheral_data_bus[0];
    end
  end

  assign translated_hi = map_on_reg ? map_value_reg
                                    : {4'h0, latched_addr_bus[15:12]};

  AST_MAP_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (map_cs_n || low_byte_write_n) |=> $stable(map_value_reg))
    else $error("map value changed without write");
  AST_MAP_ADD: assert property (@(posedge clk) disable iff (!rstn)
    (!map_cs_n && !low_byte_write_n) |=>
      map_value_reg[3:0] == 4'($past(latched_addr_bus[15:12]) + $past(peripheral_data_bus[3:0])))
    else $error("map adder result wrong");
  AST_MAP_ON: assert property (@(posedge clk) disable iff (!rstn)
    (!map_sel_n && !priority_low_n) |=> map_on_reg == $past(peripheral_data_bus[0]))
    else $error("map control not loaded");
endmodule

/* rtl/cmmg_top.sv */
// processor memory map glue: strapping, control gates, address latch, map,
// memory access decode and dynamic ram row/column/refresh multiplexing
// assumes all inputs synchronous to clk; bus pins resolved outside from enables
`timescale 1ns/1ps
`include "cmmg_cfg.svh"
// Operation
// - strap five bus lines low during clear
// - strap pattern selects clock, cycle, memory, bus
// - refresh when flag0 set, flag1 clear
// - ram row strobe follows cpu outside refresh; io qualifier
// - read flag and read strobe decode
// - low byte write strobe decode
// - latch address phase for whole transfer
// - map widens addresses to twenty bits
// - map input mux chooses address nibble
// - adders load only on map write
// - adders sum nibble with data nibbles
// - readback drives map value on read
// - map control loads data bit zero
// - output mux selects translated or plain
// - access decode enabled by io miss, strobe
// - rom read on strobe and select
// - ram row then column address
// - refresh uses row addressing only
// - column strobe per accessed byte
// - address buffer latched during column strobe
// - input mux selects refresh sources
// - output mux selects refresh row bits
// - two byte banks row-enabled together from ram row strobe
// - io hit on top four bits ones
// - map select decode from bits five, six
module cmmg_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // power-up clear
  input  wire logic        sys_clear_n,
  // processor flags and controls
  input  wire logic        cpu_flag_bit0,
  input  wire logic        cpu_flag_bit1,
  input  wire logic        cpu_row_strobe_n,
  input  wire logic        cpu_column_strobe_n,
  input  wire logic        high_byte_rw_ctl,
  input  wire logic        low_byte_rw_ctl,
  input  wire logic        priority_input,
  input  wire logic        addr_latch_en,
  input  wire logic        renew_row_bit7,
  input  wire logic        renew_row_bit6,
  // multiplexed bus pins
  input  wire logic [15:0] muxed_addr_data_lines_i,
  output logic [15:0]      muxed_addr_data_lines_o,
  output logic [15:0]      muxed_addr_data_lines_oe,
  // peripheral data bus pins
  input  wire logic [7:0]  peripheral_data_bus_i,
  output logic [7:0]       peripheral_data_bus_o,
  output logic             peripheral_data_bus_oe,
  // control gate outputs
  output logic             ram_row_strobe_n,
  output logic             io_cycle_qualifier_n,
  output logic             read_cycle,
  output logic             read_strobe_n,
  output logic             low_byte_write_n,
  output logic             refresh_active,
  // addresses
  output logic [15:1]      latched_addr_bus,
  output logic [19:12]     translated_addr_bus,
  output logic             map_on,
  output logic             io_space_hit,
  // memory selects
  output logic             firmware_select1_n,
  output logic             firmware_select2_n,
  output logic             firmware_select3_n,
  output logic             ram_select_n,
  output logic             firmware_read_n,
  // dynamic ram
  output logic [4:0]       ram_addr_low,
  output logic [2:0]       ram_addr_high,
  output logic             ram_mux_ctl,
  output logic             upper_col_strobe_n,
  output logic             lower_col_strobe_n,
  output logic             upper_bank_rw_ctl,
  output logic             lower_bank_rw_ctl,
  output logic             upper_bank_row_en,
  output logic             lower_bank_row_en
);
  logic        refresh_reg;
  logic        read_cycle_reg;
  logic        read_strobe_n_w;
  logic        low_byte_write_n_w;
  logic        map_cs_n;
  logic        map_sel_n;
  logic        map_on_w;
  logic [7:0]  map_value;
  logic [19:12] xlate_next;
  logic [15:1] latch_reg;
  logic [15:1] latch_next;
  logic        io_hit_next;
  logic        decode_en;
  cmmg_pkg::cmmg_sel_e sel_kind;
  logic [2:0]  ram_in_mux;
  logic [2:0]  ram_out_next;
  logic [4:0]  buf_next;

  function automatic logic nibble_ones(input logic [3:0] n);
    nibble_ones = (n == `CMMG_IO_HIT_NIBBLE);
  endfunction

  cmmg_flag_decode u_flags (
    .clk                      (clk),
    .rstn                     (rstn),
    .cpu_flag_bit0            (cpu_flag_bit0),
    .cpu_flag_bit1            (cpu_flag_bit1),
    .cpu_row_strobe_n         (cpu_row_strobe_n),
    .high_byte_rw_ctl         (high_byte_rw_ctl),
    .low_byte_rw_ctl          (low_byte_rw_ctl),
    .priority_input           (priority_input),
    .refresh_reg              (refresh_reg),
    .ram_row_strobe_n_reg     (ram_row_strobe_n),
    .io_cycle_qualifier_n_reg (io_cycle_qualifier_n),
    .read_cycle_reg           (read_cycle_reg),
    .read_strobe_n_reg        (read_strobe_n_w),
    .low_byte_write_n_reg     (low_byte_write_n_w)
  );

  assign refresh_active   = refresh_reg;
  assign read_cycle       = read_cycle_reg;
  assign read_strobe_n    = read_strobe_n_w;
  assign low_byte_write_n = low_byte_write_n_w;

  // strap drive: only the zero bits are driven, the rest float high by pull-up
  always_ff @(posedge clk) begin
    if (!rstn) begin
      muxed_addr_data_lines_o  <= 16'h0000;
      muxed_addr_data_lines_oe <= 16'h0000;
    end else begin
      muxed_addr_data_lines_o  <= 16'h0000;
      muxed_addr_data_lines_oe <= sys_clear_n ? 16'h0000 : `CMMG_STRAP_LOW_MASK;
    end
  end

  // address phase captured on the latch enable and held through data phase
  assign latch_next = addr_latch_en ? muxed_addr_data_lines_i[15:1] : latch_reg;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      latch_reg <= 15'h0000;
    end else begin
      latch_reg <= latch_next;
    end
  end
  assign latched_addr_bus = latch_reg;

  // io decode from the held address
  assign io_hit_next = nibble_ones(latch_reg[15:12]);
  assign map_cs_n  = !(io_hit_next && latch_reg[11:9] == `CMMG_MAP_PAGE_MID
                       && latch_reg[8:7] == 2'h0 && latch_reg[6:5] == `CMMG_MAP_CS_CODE);
  assign map_sel_n = !(io_hit_next && latch_reg[11:9] == `CMMG_MAP_PAGE_MID
                       && latch_reg[8:7] == 2'h0 && latch_reg[6:5] == `CMMG_MAP_SEL_CODE
                       && latch_reg[4:1] == 4'h0);

  cmmg_mem_map u_map (
    .clk                 (clk),
    .rstn                (rstn && sys_clear_n),
    .map_cs_n            (map_cs_n),
    .map_sel_n           (map_sel_n),
    .low_byte_write_n    (low_byte_write_n_w),
    .priority_low_n      (~priority_input),
    .latched_addr_bus    (latch_reg),
    .peripheral_data_bus (peripheral_data_bus_i),
    .map_value_reg       (map_value),
    .map_on_reg          (map_on_w),
    .translated_hi       (xlate_next)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      translated_addr_bus <= 8'h00;
      map_on              <= 1'b0;
      io_space_hit        <= 1'b0;
    end else begin
      translated_addr_bus <= xlate_next;
      map_on              <= map_on_w;
      io_space_hit        <= io_hit_next;
    end
  end

  // map readback onto the peripheral bus
  always_ff @(posedge clk) begin
    if (!rstn) begin
      peripheral_data_bus_o  <= 8'h00;
      peripheral_data_bus_oe <= 1'b0;
    end else begin
      peripheral_data_bus_o  <= map_value;
      peripheral_data_bus_oe <= !map_cs_n && !read_strobe_n_w;
    end
  end

  // memory access decode on the translated address
  assign decode_en = !io_hit_next && !cpu_row_strobe_n;
  always_comb begin
    sel_kind = cmmg_pkg::CMMG_SEL_NONE;
    if (decode_en) begin
      if (xlate_next[15:12] == `CMMG_RAM_BASE_TOP || xlate_next[19:16] != 4'h0) begin
        sel_kind = cmmg_pkg::CMMG_SEL_RAM;
      end else begin
        sel_kind = cmmg_pkg::CMMG_SEL_ROM;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      firmware_select1_n <= 1'b1;
      firmware_select2_n <= 1'b1;
      firmware_select3_n <= 1'b1;
      ram_select_n       <= 1'b1;
      firmware_read_n    <= 1'b1;
    end else begin
      firmware_select1_n <= !(sel_kind == cmmg_pkg::CMMG_SEL_ROM && xlate_next[15:14] == 2'h0);
      firmware_select2_n <= !(sel_kind == cmmg_pkg::CMMG_SEL_ROM && xlate_next[15:14] == 2'h1);
      firmware_select3_n <= !(sel_kind == cmmg_pkg::CMMG_SEL_ROM && xlate_next[15] == 1'b1);
      ram_select_n       <= sel_kind != cmmg_pkg::CMMG_SEL_RAM;
      firmware_read_n    <= sel_kind != cmmg_pkg::CMMG_SEL_ROM;
    end
  end

  // ram address multiplexing: refresh drives row bits only
  assign ram_in_mux   = refresh_reg ? {1'b0, renew_row_bit7, 1'b1}
                                    : {xlate_next[15], xlate_next[13], ram_row_strobe_n};
  assign ram_out_next = ram_in_mux[0] ? {1'b0, ram_in_mux[1], renew_row_bit6}
                                      : {xlate_next[16], xlate_next[14], xlate_next[12]};
  assign buf_next     = cpu_column_strobe_n ? latch_reg[5:1] : ram_addr_low;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ram_addr_low  <= 5'h00;
      ram_addr_high <= 3'h0;
      ram_mux_ctl   <= 1'b0;
    end else begin
      ram_addr_low  <= buf_next;
      ram_addr_high <= ram_out_next;
      ram_mux_ctl   <= ram_in_mux[0];
    end
  end

  // byte column strobes: reads take the word, writes the byte asked for
  always_ff @(posedge clk) begin
    if (!rstn) begin
      upper_col_strobe_n <= 1'b1;
      lower_col_strobe_n <= 1'b1;
      upper_bank_rw_ctl  <= 1'b1;
      lower_bank_rw_ctl  <= 1'b1;
      upper_bank_row_en  <= 1'b0;
      lower_bank_row_en  <= 1'b0;
    end else begin
      upper_col_strobe_n <= !(sel_kind == cmmg_pkg::CMMG_SEL_RAM && !cpu_column_strobe_n
                              && (read_cycle_reg || !high_byte_rw_ctl));
      lower_col_strobe_n <= !(sel_kind == cmmg_pkg::CMMG_SEL_RAM && !cpu_column_strobe_n
                              && (read_cycle_reg || !low_byte_rw_ctl));
      upper_bank_rw_ctl  <= high_byte_rw_ctl;
      lower_bank_rw_ctl  <= low_byte_rw_ctl;
      upper_bank_row_en  <= !ram_row_strobe_n;
      lower_bank_row_en  <= !ram_row_strobe_n;
    end
  end

  sequence s_clear_low;
    !sys_clear_n;
  endsequence
  AST_STRAP: assert property (@(posedge clk) disable iff (!rstn)
    s_clear_low |=> (muxed_addr_data_lines_oe == `CMMG_STRAP_LOW_MASK && muxed_addr_data_lines_o == 16'h0000))
    else $error("strap not driven");
  AST_STRAP_OFF: assert property (@(posedge clk) disable iff (!rstn)
    sys_clear_n |=> muxed_addr_data_lines_oe == 16'h0000)
    else $error("strap driven outside clear");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    !addr_latch_en |=> $stable(latched_addr_bus))
    else $error("latched address moved");
  AST_IO_HIT: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> io_space_hit == ($past(latched_addr_bus[15:12]) == 4'hF))
    else $error("io hit wrong");
  AST_READBACK: assert property (@(posedge clk) disable iff (!rstn)
    (!map_cs_n && !read_strobe_n) |=> peripheral_data_bus_oe)
    else $error("readback not driven");
  AST_NO_SEL_IO: assert property (@(posedge clk) disable iff (!rstn)
    (io_hit_next || cpu_row_strobe_n) |=> (ram_select_n && firmware_read_n))
    else $error("memory selected outside access");
  AST_REFRESH_ROW: assert property (@(posedge clk) disable iff (!rstn)
    refresh_reg |=> (ram_mux_ctl && ram_addr_high[2] == 1'b0 && ram_addr_high[1] == $past(renew_row_bit7)
                     && ram_addr_high[0] == $past(renew_row_bit6)))
    else $error("refresh row mux wrong");
  AST_BUF_LATCH: assert property (@(posedge clk) disable iff (!rstn)
    !cpu_column_strobe_n |=> $stable(ram_addr_low))
    else $error("address buffer not latched");
endmodule

/* tb/cmmg_cpu_model.sv */
// processor side of the memory map glue: owns the muxed bus and the latch strobe
// assumes the glue samples on rising clk; the model changes lines on falling edges
`timescale 1ns/1ps
module cmmg_cpu_model (
  // clock and power-up clear
  input  wire logic        clk,
  input  wire logic        sys_clear_n,
  // glue side of the bus pins
  input  wire logic [15:0] glue_o,
  input  wire logic [15:0] glue_oe,
  // resolved bus and address strobe
  output logic [15:0]      bus,
  output logic             latch_en
);
  logic [15:0] cpu_d;

  // the processor floats the bus during clear; pull-ups hold undriven lines high
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      bus[i] = glue_oe[i] ? glue_o[i] : (sys_clear_n ? cpu_d[i] : 1'h1);
    end
  end

  initial begin
    cpu_d = 16'h0000;
    latch_en = 1'h0;
  end

  // one address cycle, then the data phase shows the inverse so a leaky latch is caught
  task automatic addr_phase(input logic [15:0] a);
    @(negedge clk);
    cpu_d = a;
    latch_en = 1'h1;
    @(negedge clk);
    latch_en = 1'h0;
    cpu_d = ~a;
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the memory map glue: gate table, map, strap, decode, ram muxing
// assumes outputs settle one edge after inputs, translated bus two edges after a latch
`timescale 1ns/1ps
module testbench;
  logic         clk = 1'h0;
  logic         rstn, sys_clear_n, f0, f1, rs_n, cs_n, hb, lb, pi, r7, r6, latch_en;
  logic [15:0]  bus, g_o, g_oe;
  logic [7:0]   pd_i, pd_o;
  logic         pd_oe, rras_n, ioq_n, rd, drd_n, wlb_n, ref_a, map_on, io_hit;
  logic         fs1_n, fs2_n, fs3_n, rams_n, frd_n, mux_c, ucs_n, lcs_n, urw, lrw, uen, len;
  logic [15:1]  la;
  logic [19:12] ta;
  logic [4:0]   ral;
  logic [2:0]   rah;
  int           n_errors = 0;
  int           n_compared = 0;
  int           cycles = 0;
  // {flag0, flag1, row strobe, hb, lb, pi} beside {refresh, rras, busop, rd, drd, wlb}
  logic [11:0]  rows [8] = '{12'h3D5, 12'h187, 12'h8FB, 12'hB7A, 12'h61B, 12'h5CD, 12'hD0B, 12'hE9B};
  // {address, rom1, rom2, rom3, ram, firmware read}
  logic [20:0]  dec [5] = '{21'h00001D, 21'h06000E, 21'h080016, 21'h10001A, 21'h1E001F};

  always #50 clk = ~clk;

  cmmg_top i_cmmg_top (
    .clk(clk), .rstn(rstn), .sys_clear_n(sys_clear_n), .cpu_flag_bit0(f0), .cpu_flag_bit1(f1),
    .cpu_row_strobe_n(rs_n), .cpu_column_strobe_n(cs_n), .high_byte_rw_ctl(hb), .low_byte_rw_ctl(lb),
    .priority_input(pi), .addr_latch_en(latch_en), .renew_row_bit7(r7), .renew_row_bit6(r6),
    .muxed_addr_data_lines_i(bus), .muxed_addr_data_lines_o(g_o), .muxed_addr_data_lines_oe(g_oe),
    .peripheral_data_bus_i(pd_i), .peripheral_data_bus_o(pd_o), .peripheral_data_bus_oe(pd_oe),
    .ram_row_strobe_n(rras_n), .io_cycle_qualifier_n(ioq_n), .read_cycle(rd), .read_strobe_n(drd_n),
    .low_byte_write_n(wlb_n), .refresh_active(ref_a), .latched_addr_bus(la), .translated_addr_bus(ta),
    .map_on(map_on), .io_space_hit(io_hit), .firmware_select1_n(fs1_n), .firmware_select2_n(fs2_n),
    .firmware_select3_n(fs3_n), .ram_select_n(rams_n), .firmware_read_n(frd_n), .ram_addr_low(ral),
    .ram_addr_high(rah), .ram_mux_ctl(mux_c), .upper_col_strobe_n(ucs_n), .lower_col_strobe_n(lcs_n),
    .upper_bank_rw_ctl(urw), .lower_bank_rw_ctl(lrw), .upper_bank_row_en(uen), .lower_bank_row_en(len)
  );

  cmmg_cpu_model i_cmmg_cpu_model (
    .clk(clk), .sys_clear_n(sys_clear_n), .glue_o(g_o), .glue_oe(g_oe), .bus(bus), .latch_en(latch_en)
  );

  task automatic chk_vec(input logic [19:0] got, input logic [19:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic addr(input logic [15:0] a);
    i_cmmg_cpu_model.addr_phase(a);
  endtask

  // three cycles of priority with the given low-byte control, long enough for the registered strobe
  task automatic strobe(input logic l, input logic [7:0] d);
    pd_i = d;
    lb = l;
    pi = 1'h1;
    cyc(3);
    lb = 1'h1;
    pi = 1'h0;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test();
    end
  end

  initial begin
    {rstn, sys_clear_n, f0, f1, rs_n, cs_n, hb, lb, pi, r7, r6} = 11'h278;
    pd_i = 8'h00;
    cyc(10);
    chk_vec({drd_n, wlb_n, fs1_n, rams_n, map_on, pd_oe}, 6'h3C, "reset");
    rstn = 1'h1;
    done("reset");
    foreach (rows[i]) begin
      {f0, f1, rs_n, hb, lb, pi} = rows[i][11:6];
      cyc(1);
      chk_vec({ref_a, rras_n, ioq_n, rd, drd_n, wlb_n}, rows[i][5:0], "gates");
    end
    {f0, f1, rs_n, hb, lb, pi} = 6'h0E;
    done("gates");
    addr(16'hF000);
    cyc(1);
    chk_vec({io_hit, la}, {1'h1, 15'h7800}, "latch");
    strobe(1'h0, 8'h23);
    // same write outside the map window must leave the sums alone
    addr(16'h1000);
    strobe(1'h0, 8'h55);
    addr(16'hF000);
    {hb, lb, pi} = 3'h7;
    cyc(3);
    chk_vec({pd_oe, pd_o}, 9'h112, "readback");
    pi = 1'h0;
    cyc(2);
    chk_bit(pd_oe, 1'h0, "release");
    addr(16'hF020);
    strobe(1'h1, 8'h01);
    chk_bit(map_on, 1'h1, "map on");
    addr(16'h3000);
    cyc(2);
    chk_vec(ta, 8'h12, "mapped");
    sys_clear_n = 1'h0;
    cyc(2);
    chk_vec(bus, 16'hB4FE, "strap");
    chk_bit(map_on, 1'h0, "clear");
    sys_clear_n = 1'h1;
    addr(16'h3000);
    cyc(2);
    chk_vec(ta, 8'h03, "plain");
    done("map");
    foreach (dec[i]) begin
      addr(dec[i][20:5]);
      rs_n = 1'h0;
      cyc(4);
      chk_vec({fs1_n, fs2_n, fs3_n, rams_n, frd_n}, dec[i][4:0], "decode");
      rs_n = 1'h1;
      cyc(2);
      chk_vec({fs1_n, fs2_n, fs3_n, rams_n, frd_n}, 5'h1F, "idle");
    end
    done("decode");
    addr(16'h002A);
    cyc(1);
    {rs_n, cs_n} = 2'h0;
    cyc(4);
    chk_vec({ucs_n, lcs_n, uen, len}, 4'h3, "read cas");
    lb = 1'h0;
    cyc(2);
    chk_vec({ucs_n, lcs_n, lrw, urw}, 4'h9, "write cas");
    // a new address while the column strobe is low must not reach the ram pins
    addr(16'h0004);
    chk_vec(ral, 5'h15, "column hold");
    {rs_n, cs_n, lb} = 3'h7;
    cyc(2);
    chk_vec(ral, 5'h02, "row pass");
    done("column");
    addr(16'h5000);
    rs_n = 1'h0;
    cyc(3);
    chk_vec({mux_c, rah}, 4'h3, "row addr");
    {f0, r7} = 2'h3;
    cyc(3);
    chk_vec({ref_a, rras_n, mux_c, rah}, 6'h3A, "refresh");
    {f0, r7, rs_n} = 3'h1;
    done("refresh");
    rstn = 1'h0;
    cyc(2);
    chk_vec({ref_a, rras_n, mux_c, rah, ucs_n, lcs_n, uen, len, ral}, 15'h2180, "mid reset");
    rstn = 1'h1;
    cyc(2);
    chk_vec({ta, ral, mux_c}, 14'h0001, "after reset");
    done("mid reset");
    stop_test();
  end
endmodule
